// *** design/bti_fwd_gate.sv ***
// forwarding and error reporting gate steered by the command bits
`timescale 1ns/1ps
module bti_fwd_gate (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // command enables
  bti_cmd_if.gate cif,
  // primary window hits
  input wire logic io_hit_i,
  input wire logic mem_hit_i,
  // upstream traffic from the secondary side
  input wire logic up_valid_i,
  input wire bti_pkg::bti_req_kind_t up_kind_i,
  input wire logic up_nonposted_i,
  // error inputs
  input wire logic sec_corr_i,
  input wire logic sec_nonfatal_i,
  input wire logic sec_fatal_i,
  input wire logic own_nonfatal_i,
  input wire logic own_fatal_i,
  input wire logic devctl_nonfatal_i,
  input wire logic devctl_fatal_i,
  input wire logic poison_cpl_down_i,
  input wire logic poison_req_up_i,
  // decisions, one cycle after the inputs
  output bti_pkg::bti_gate_t g_o
);
  bti_pkg::bti_gate_t g_r, g_nxt;
  logic gated;

  always_comb begin
    gated = (up_kind_i == bti_pkg::BTI_REQ_MEM) || (up_kind_i == bti_pkg::BTI_REQ_IO);
    g_nxt = '0;
    g_nxt.io_claim = io_hit_i && cif.io_en;
    g_nxt.mem_claim = mem_hit_i && cif.mem_en;
    // completions and other messages pass whatever the enable says
    g_nxt.up_fwd = up_valid_i && (!gated || cif.fwd_en);
    g_nxt.up_ur = up_valid_i && gated && !cif.fwd_en;
    g_nxt.up_ur_cpl = up_valid_i && gated && !cif.fwd_en && up_nonposted_i;
    g_nxt.corr_fwd = sec_corr_i;
    g_nxt.nonfatal_fwd = sec_nonfatal_i && cif.serr_en;
    g_nxt.fatal_fwd = sec_fatal_i && cif.serr_en;
    g_nxt.rep_nonfatal = own_nonfatal_i && (cif.serr_en || devctl_nonfatal_i);
    g_nxt.rep_fatal = own_fatal_i && (cif.serr_en || devctl_fatal_i);
    g_nxt.poison_evt = (poison_cpl_down_i || poison_req_up_i) && cif.poison_en;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      g_r <= '0;
    end else begin
      g_r <= g_nxt;
    end
  end

  assign g_o = g_r;
  assign cif.poison_evt = g_r.poison_evt;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_io_gate;
    io_hit_i && !cif.io_en |=> !g_o.io_claim;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io claimed while disabled");
  property p_mem_gate;
    mem_hit_i |=> g_o.mem_claim == $past(cif.mem_en);
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory claim wrong");
  property p_bm_off;
    up_valid_i && !cif.fwd_en && up_kind_i == bti_pkg::BTI_REQ_MEM |=> g_o.up_ur && !g_o.up_fwd;
  endproperty
  a_bm_off: assert property (p_bm_off) else $error("memory request forwarded with mastering off");
  property p_ur_cpl;
    up_valid_i && up_nonposted_i && !cif.fwd_en && up_kind_i == bti_pkg::BTI_REQ_IO |=> g_o.up_ur_cpl;
  endproperty
  a_ur_cpl: assert property (p_ur_cpl) else $error("no unsupported completion");
  property p_cpl_pass;
    up_valid_i && up_kind_i inside {bti_pkg::BTI_REQ_CPL, bti_pkg::BTI_REQ_OTHER} |=> g_o.up_fwd && !g_o.up_ur;
  endproperty
  a_cpl_pass: assert property (p_cpl_pass) else $error("completion blocked");
  property p_fatal_msg;
    sec_fatal_i ##1 !$past(cif.serr_en) |-> !g_o.fatal_fwd;
  endproperty
  a_fatal_msg: assert property (p_fatal_msg) else $error("fatal message forwarded while disabled");
  property p_corr_msg;
    sec_corr_i |=> g_o.corr_fwd;
  endproperty
  a_corr_msg: assert property (p_corr_msg) else $error("correctable message dropped");
  property p_report;
    own_nonfatal_i && cif.serr_en |=> g_o.rep_nonfatal;
  endproperty
  a_report: assert property (p_report) else $error("non-fatal error not reported");
  property p_poison_off;
    !cif.poison_en |=> !g_o.poison_evt;
  endproperty
  a_poison_off: assert property (p_poison_off) else $error("poison logged while disabled");
  c_ur: cover property (up_valid_i && !cif.fwd_en ##1 g_o.up_ur_cpl);
  c_fwd: cover property (up_valid_i && cif.fwd_en ##1 g_o.up_fwd);
endmodule // bti_fwd_gate

// *** design/bti_regs.sv ***
// bridge identification and command register bank with its axi4-lite slave
// Operation
// - offset zero reads a fixed 16-bit vendor code that writes never change.
// - offset two reads a fixed 16-bit device code for this bridge function.
// - with command bit 0 clear, primary io accesses in the io window are not claimed; it resets to 0.
// - with command bit 1 clear, primary memory and prefetchable window accesses are not claimed; reset 0.
// - with command bit 2 clear, upstream memory, io and msi requests are not forwarded but made unsupported.
// - with bus mastering off, each upstream non-posted memory or io request gets an unsupported-request completion.
// - the mastering bit never touches completions nor requests other than memory and io.
// - command bits 3, 4, 5 and 7 read as zero and cannot be written.
// - command bit 6, reset 0, decides whether poisoned traffic is logged in the status register.
// - own non-fatal and fatal errors are reported when bit 8 or the device control bits allow it.
// - non-fatal and fatal messages from the secondary side pass upward only while bit 8 is set.
// - correctable messages from the secondary side always pass upward.
// - status bit 8 sets on a logged poisoned downstream completion or upstream request, write one clears.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bti_defs.svh"
module bti_regs #(
  parameter logic [15:0] VENDOR_CODE = 16'h5a5a, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0001 // arbitrary value
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // primary window hits from the address decoders
  input wire logic io_hit_i,
  input wire logic mem_hit_i,
  // upstream traffic from the secondary side
  input wire logic up_valid_i,
  input wire logic [1:0] up_kind_i,
  input wire logic up_nonposted_i,
  // error and poison events
  input wire logic sec_corr_i,
  input wire logic sec_nonfatal_i,
  input wire logic sec_fatal_i,
  input wire logic own_nonfatal_i,
  input wire logic own_fatal_i,
  input wire logic devctl_nonfatal_i,
  input wire logic devctl_fatal_i,
  input wire logic poison_cpl_down_i,
  input wire logic poison_req_up_i,
  // forwarding decisions
  output logic io_claim_o,
  output logic mem_claim_o,
  output logic up_fwd_o,
  output logic up_ur_o,
  output logic up_ur_cpl_o,
  output logic corr_fwd_o,
  output logic nonfatal_fwd_o,
  output logic fatal_fwd_o,
  output logic rep_nonfatal_o,
  output logic rep_fatal_o
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_n <= rst_meta_r;
    end
  end

  // ****************************************
  // state
  // ****************************************
  bti_pkg::bti_regs_t s_r, s_nxt;
  bti_pkg::bti_gate_t g;
  bti_cmd_if cif ();
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do;
  logic [15:0] cmd_merged;
  logic [15:0] sts_view;

  // read mux: {resp, data} for a register index
  function automatic logic [17:0] rd_word(input logic [13:0] idx, input logic [15:0] cmd,
                                          input logic [15:0] sts);
    logic [17:0] v;
    case (idx)
      `BTI_IDX_VENDOR: v = {`BTI_RESP_OKAY, VENDOR_CODE};
      `BTI_IDX_DEVICE: v = {`BTI_RESP_OKAY, DEVICE_CODE};
      `BTI_IDX_CMD: v = {`BTI_RESP_OKAY, cmd};
      `BTI_IDX_STS: v = {`BTI_RESP_OKAY, sts};
      default: v = {`BTI_RESP_DECERR, 16'h0000};
    endcase
    return v;
  endfunction

  // ****************************************
  // bus handshakes
  // ****************************************
  // one write in flight: both channels stall while a response waits
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_do = s_r.aw_got && s_r.w_got;

  always_comb begin
    sts_view = 16'h0000;
    sts_view[`BTI_STS_MPD] = s_r.mpd;
    cmd_merged = s_r.cmd;
    if (s_r.wstrb[0]) begin
      cmd_merged[7:0] = s_r.wdata[7:0];
    end
    if (s_r.wstrb[1]) begin
      cmd_merged[15:8] = s_r.wdata[15:8];
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    if (aw_fire) begin
      s_nxt.aw_got = 1'h1;
      s_nxt.aw_idx = s_axi_awaddr[15:2];
    end
    if (w_fire) begin
      s_nxt.w_got = 1'h1;
      s_nxt.wdata = s_axi_wdata[15:0];
      s_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'h0;
    end
    if (wr_do) begin
      s_nxt.aw_got = 1'h0;
      s_nxt.w_got = 1'h0;
      s_nxt.bvalid = 1'h1;
      s_nxt.bresp = `BTI_RESP_OKAY;
      case (s_r.aw_idx)
        `BTI_IDX_VENDOR, `BTI_IDX_DEVICE: begin
          s_nxt.bresp = `BTI_RESP_OKAY;
        end
        `BTI_IDX_CMD: begin
          // only the writable enables take the data, the rest stay zero
          s_nxt.cmd = cmd_merged & `BTI_CMD_RW_MASK;
        end
        `BTI_IDX_STS: begin
          if (s_r.wstrb[1] && s_r.wdata[`BTI_STS_MPD]) begin
            s_nxt.mpd = 1'h0;
          end
        end
        default: begin
          s_nxt.bresp = `BTI_RESP_DECERR;
        end
      endcase
    end
    // a poison event in the clearing cycle still lands
    if (cif.poison_evt) begin
      s_nxt.mpd = 1'h1;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'h0;
    end
    if (ar_fire) begin
      s_nxt.rvalid = 1'h1;
      {s_nxt.rresp, s_nxt.rdata} = rd_word(s_axi_araddr[15:2], s_r.cmd, sts_view);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.cmd <= `BTI_CMD_RST;
      s_r.mpd <= `BTI_MPD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = {16'h0000, s_r.rdata};
  assign s_axi_rresp = s_r.rresp;

  assign cif.io_en = s_r.cmd[`BTI_CMD_IO];
  assign cif.mem_en = s_r.cmd[`BTI_CMD_MEM];
  assign cif.fwd_en = s_r.cmd[`BTI_CMD_FWD];
  assign cif.poison_en = s_r.cmd[`BTI_CMD_POISON];
  assign cif.serr_en = s_r.cmd[`BTI_CMD_SERR];

  // ****************************************
  // forwarding gate
  // ****************************************
  bti_fwd_gate u_gate (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .cif(cif.gate),
    .io_hit_i(io_hit_i),
    .mem_hit_i(mem_hit_i),
    .up_valid_i(up_valid_i),
    .up_kind_i(bti_pkg::bti_req_kind_t'(up_kind_i)),
    .up_nonposted_i(up_nonposted_i),
    .sec_corr_i(sec_corr_i),
    .sec_nonfatal_i(sec_nonfatal_i),
    .sec_fatal_i(sec_fatal_i),
    .own_nonfatal_i(own_nonfatal_i),
    .own_fatal_i(own_fatal_i),
    .devctl_nonfatal_i(devctl_nonfatal_i),
    .devctl_fatal_i(devctl_fatal_i),
    .poison_cpl_down_i(poison_cpl_down_i),
    .poison_req_up_i(poison_req_up_i),
    .g_o(g)
  );

  assign io_claim_o = g.io_claim;
  assign mem_claim_o = g.mem_claim;
  assign up_fwd_o = g.up_fwd;
  assign up_ur_o = g.up_ur;
  assign up_ur_cpl_o = g.up_ur_cpl;
  assign corr_fwd_o = g.corr_fwd;
  assign nonfatal_fwd_o = g.nonfatal_fwd;
  assign fatal_fwd_o = g.fatal_fwd;
  assign rep_nonfatal_o = g.rep_nonfatal;
  assign rep_fatal_o = g.rep_fatal;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  property p_vendor_read;
    ar_fire && s_axi_araddr[15:2] == `BTI_IDX_VENDOR |=> s_axi_rvalid && s_axi_rdata == {16'h0000, VENDOR_CODE};
  endproperty
  a_vendor_read: assert property (p_vendor_read) else $error("vendor code read wrong");

  property p_device_read;
    ar_fire && s_axi_araddr[15:2] == `BTI_IDX_DEVICE |=> s_axi_rvalid && s_axi_rdata[15:0] == DEVICE_CODE;
  endproperty
  a_device_read: assert property (p_device_read) else $error("device code read wrong");

  property p_cmd_hard0;
    wr_do && s_r.aw_idx == `BTI_IDX_CMD && s_r.wstrb == 2'h3 && s_r.wdata == 16'hffff
      |=> s_r.cmd == `BTI_CMD_RW_MASK;
  endproperty
  a_cmd_hard0: assert property (p_cmd_hard0) else $error("command write wrong");

  property p_ro_write;
    wr_do && s_r.aw_idx == `BTI_IDX_VENDOR |=> $stable(s_r.cmd) && s_axi_bresp == `BTI_RESP_OKAY;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_mpd_set;
    (poison_cpl_down_i || poison_req_up_i) && cif.poison_en |-> ##2 s_r.mpd;
  endproperty
  a_mpd_set: assert property (p_mpd_set) else $error("poison not logged");

  property p_mpd_clear;
    wr_do && s_r.aw_idx == `BTI_IDX_STS && s_r.wstrb[1] && s_r.wdata[`BTI_STS_MPD] && !cif.poison_evt
      |=> !s_r.mpd;
  endproperty
  a_mpd_clear: assert property (p_mpd_clear) else $error("status clear failed");

  property p_bm_reg;
    wr_do && s_r.aw_idx == `BTI_IDX_CMD && s_r.wstrb[0] && !s_r.wdata[`BTI_CMD_FWD]
      ##1 up_valid_i && up_kind_i == 2'h0 |=> up_ur_o;
  endproperty
  a_bm_reg: assert property (p_bm_reg) else $error("cleared mastering still forwards");

  property p_wr_answer;
    aw_fire && w_fire |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  c_cmd_wr: cover property (wr_do && s_r.aw_idx == `BTI_IDX_CMD);
  c_vendor_rd: cover property (ar_fire && s_axi_araddr[15:2] == `BTI_IDX_VENDOR);
  c_mpd: cover property (cif.poison_evt ##1 s_r.mpd);
endmodule // bti_regs

// *** pkg/bti_cmd_if.sv ***
// command enables towards the forwarding gate and poison events back
`timescale 1ns/1ps
interface bti_cmd_if;
  logic io_en;
  logic mem_en;
  logic fwd_en;
  logic poison_en;
  logic serr_en;
  logic poison_evt;
  modport regs (output io_en, output mem_en, output fwd_en, output poison_en, output serr_en, input poison_evt);
  modport gate (input io_en, input mem_en, input fwd_en, input poison_en, input serr_en, output poison_evt);
endinterface

// *** pkg/bti_defs.svh ***
// constants for the bridge identification and command register bank
`ifndef BTI_DEFS_SVH
`define BTI_DEFS_SVH
// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define BTI_IDX_VENDOR 14'h0000
`define BTI_IDX_DEVICE 14'h0002
`define BTI_IDX_CMD 14'h0004
`define BTI_IDX_STS 14'h0006
// ****************************************
// command and status fields
// ****************************************
`define BTI_CMD_IO 0
`define BTI_CMD_MEM 1
`define BTI_CMD_FWD 2
`define BTI_CMD_POISON 6
`define BTI_CMD_SERR 8
`define BTI_CMD_RW_MASK 16'h0147
`define BTI_CMD_RST 16'h0000
`define BTI_STS_MPD 8
`define BTI_MPD_RST 1'h0
// ****************************************
// bus answers
// ****************************************
`define BTI_RESP_OKAY 2'h0
`define BTI_RESP_DECERR 2'h3
`endif

// *** pkg/bti_pkg.sv ***
// types for the bridge identification and command register bank
package bti_pkg;
  typedef enum logic [1:0] {BTI_REQ_MEM, BTI_REQ_IO, BTI_REQ_OTHER, BTI_REQ_CPL} bti_req_kind_t;

  typedef struct packed {
    logic aw_got;
    logic [13:0] aw_idx;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] cmd;
    logic mpd;
  } bti_regs_t;

  typedef struct packed {
    logic io_claim;
    logic mem_claim;
    logic up_fwd;
    logic up_ur;
    logic up_ur_cpl;
    logic corr_fwd;
    logic nonfatal_fwd;
    logic fatal_fwd;
    logic rep_nonfatal;
    logic rep_fatal;
    logic poison_evt;
  } bti_gate_t;
endpackage

// *** tb/bti_rc_model.sv ***
// root complex side model issuing configuration accesses over axi4-lite
`timescale 1ns/1ps
module bti_rc_model (
  // clock
  input wire logic mclk_i,
  // write channels
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [15:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [15:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
  end

  // ****************************************
  // configuration write, lanes 0 and 1 at least
  // ****************************************
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // ****************************************
  // configuration read, rready held back lag cycles
  // ****************************************
  task automatic rd(input logic [15:0] a, input int lag, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= (lag == 0);
    forever begin
      @(posedge mclk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (n >= lag) s_axi_rready <= 1'b1;
    end
  endtask
endmodule // bti_rc_model

// *** tb/tb.sv ***
// self-checking bench for the bridge identification and command register bank
`timescale 1ns/1ps
`include "bti_defs.svh"
module tb;
  localparam logic [15:0] VEND = 16'h3c3c; // arbitrary value
  localparam logic [15:0] DEVC = 16'h0042; // arbitrary value
  logic mclk_i;
  logic resetn_i;
  logic [12:0] gin;
  logic [1:0] pois;
  logic [9:0] gout;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, up_kind;
  logic io_hit, mem_hit, up_valid, up_np, s_corr, s_nf, s_fa, o_nf, o_fa, d_nf, d_fa;
  logic [15:0] cmd;
  logic [15:0] cv [4] = '{16'h0000, 16'hffff, 16'h0004, 16'h0100};
  int fail_count;
  int checks;
  int cycles;
  assign {io_hit, mem_hit, up_valid, up_kind, up_np, s_corr, s_nf, s_fa, o_nf, o_fa, d_nf, d_fa} = gin;

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  bti_regs #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEVC)) i_bti_regs (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .io_hit_i(io_hit), .mem_hit_i(mem_hit), .up_valid_i(up_valid), .up_kind_i(up_kind),
    .up_nonposted_i(up_np), .sec_corr_i(s_corr), .sec_nonfatal_i(s_nf), .sec_fatal_i(s_fa),
    .own_nonfatal_i(o_nf), .own_fatal_i(o_fa), .devctl_nonfatal_i(d_nf), .devctl_fatal_i(d_fa),
    .poison_cpl_down_i(pois[1]), .poison_req_up_i(pois[0]),
    .io_claim_o(gout[9]), .mem_claim_o(gout[8]), .up_fwd_o(gout[7]), .up_ur_o(gout[6]),
    .up_ur_cpl_o(gout[5]), .corr_fwd_o(gout[4]), .nonfatal_fwd_o(gout[3]), .fatal_fwd_o(gout[2]),
    .rep_nonfatal_o(gout[1]), .rep_fatal_o(gout[0])
  );

  bti_rc_model i_bti_rc_model (
    .mclk_i(mclk_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [9:0] exp_gate(input logic [15:0] c, input logic [12:0] v);
    logic io, mem, uv, np, co, nf, fa, onf, ofa, dnf, dfa, mio, ur;
    logic [1:0] k;
    {io, mem, uv, k, np, co, nf, fa, onf, ofa, dnf, dfa} = v;
    mio = (k == 2'h0) || (k == 2'h1);
    ur = uv & mio & !c[`BTI_CMD_FWD];
    return {io & c[0], mem & c[1], uv & !ur, ur, ur & np, co, nf & c[8], fa & c[8], onf & (c[8] | dnf), ofa & (c[8] | dfa)};
  endfunction

  task automatic wrchk(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    i_bti_rc_model.wr(a, d, s, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_bti_rc_model.rd(a, $urandom_range(3), d, r);
    chk("rdata", d, {16'h0000, e});
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic setcmd(input logic [15:0] v);
    wrchk(16'h0010, {16'h0000, v}, 4'h3, `BTI_RESP_OKAY);
    cmd = v & `BTI_CMD_RW_MASK;
    rdchk(16'h0010, cmd, `BTI_RESP_OKAY);
  endtask

  // random traffic; outputs show last edge's inputs gated by cmd
  task automatic gate_run(input int n);
    logic [12:0] prev;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      prev = gin;
      gin <= 13'($urandom);
      #1;
      chk("gate", {22'h0, gout}, {22'h0, exp_gate(cmd, prev)});
    end
  endtask

  task automatic pulse(input logic [1:0] p);
    @(posedge mclk_i);
    pois <= p;
    @(posedge mclk_i);
    pois <= 2'h0;
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'he082));
    resetn_i = 1'b0;
    gin = 13'h0000;
    pois = 2'h0;
    cmd = 16'h0000;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdchk(16'h0000, VEND, `BTI_RESP_OKAY);
    rdchk(16'h0008, DEVC, `BTI_RESP_OKAY);
    rdchk(16'h0010, `BTI_CMD_RST, `BTI_RESP_OKAY);
    rdchk(16'h0018, 16'h0000, `BTI_RESP_OKAY);
    wrchk(16'h0000, 32'hffffffff, 4'hf, `BTI_RESP_OKAY);
    wrchk(16'h0008, 32'hffffffff, 4'hf, `BTI_RESP_OKAY);
    rdchk(16'h0000, VEND, `BTI_RESP_OKAY);
    rdchk(16'h0008, DEVC, `BTI_RESP_OKAY);
    wrchk(16'h0020, 32'h00000001, 4'h3, `BTI_RESP_DECERR);
    rdchk(16'h0020, 16'h0000, `BTI_RESP_DECERR);
    for (int i = 0; i < 7; i++) begin
      setcmd(i < 4 ? cv[i % 4] : 16'($urandom));
      gate_run(64);
    end
    setcmd(16'hffff);
    // read-only bits written high must still read zero
    wrchk(16'h0010, 32'h0000feb8, 4'h3, `BTI_RESP_OKAY);
    rdchk(16'h0010, 16'h0000, `BTI_RESP_OKAY);
    // mastering cleared while a non-posted memory request waits
    gin <= 13'h0480;
    setcmd(16'h0000);
    gate_run(4);
    pulse(2'h3);
    rdchk(16'h0018, 16'h0000, `BTI_RESP_OKAY);
    setcmd(16'h0040);
    pulse(2'h2);
    rdchk(16'h0018, 16'h0100, `BTI_RESP_OKAY);
    wrchk(16'h0018, 32'h00000000, 4'h3, `BTI_RESP_OKAY);
    rdchk(16'h0018, 16'h0100, `BTI_RESP_OKAY);
    wrchk(16'h0018, 32'h00000100, 4'h3, `BTI_RESP_OKAY);
    rdchk(16'h0018, 16'h0000, `BTI_RESP_OKAY);
    pulse(2'h1);
    rdchk(16'h0018, 16'h0100, `BTI_RESP_OKAY);
    report_and_stop();
  end
endmodule // tb
